// ---- core/enhanced_capture_compare_unit.sv ----
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "capture_compare_defines.svh"

module enhanced_capture_compare_unit
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] timer_value,
  input  wire logic        timer_tick,
  input  wire logic        timer_overflow,
  input  wire logic        adc_enabled,
  input  wire logic        pwm_modulated,
  input  wire logic        pin_a_in,
  output logic             output_a,
  output logic             output_b,
  output logic             output_c,
  output logic             output_d,
  output logic             output_a_oe_n,
  output logic             output_b_oe_n,
  output logic             output_c_oe_n,
  output logic             output_d_oe_n,
  output logic             special_trigger,
  output logic             timer_clear,
  output logic             adc_start,
  output logic      [9:0]  duty_value
);

  // --------------------------------------------------------------
  // mode decoding
  // --------------------------------------------------------------
  function automatic capture_compare_pkg::mode_class_type mode_class
  (
    input logic [3:0] mode
  );
    capture_compare_pkg::mode_class_type cls;
    cls = capture_compare_pkg::class_compare;
    if (mode == `MODE_OFF)
      cls = capture_compare_pkg::class_off;
    else if (mode == 4'h1 || mode == 4'h3)
      cls = capture_compare_pkg::class_reserved;
    else if (mode[3:2] == 2'b01)
      cls = capture_compare_pkg::class_capture;
    else if (mode[3:2] == 2'b11)
      cls = capture_compare_pkg::class_pwm;
    return cls;
  endfunction

  logic [7:0]  control_q;
  logic [15:0] hold_q;
  logic [7:0]  enables_q;
  logic        unit_flag_q;
  logic        timer_flag_q;
  logic [3:0]  presc_q;
  logic        cmp_latch_q;
  logic        match_prev_q;
  logic        reset_pend_q;

  wire [3:0] mode_select          = control_q[3:0];
  wire [1:0] output_configuration = control_q[7:6];
  wire [1:0] duty_low_bits        = control_q[5:4];

  capture_compare_pkg::mode_class_type cur_class;
  assign cur_class = mode_class(mode_select);

  wire is_capture = (cur_class == capture_compare_pkg::class_capture);
  wire is_compare = (cur_class == capture_compare_pkg::class_compare);
  wire is_pwm     = (cur_class == capture_compare_pkg::class_pwm);

  // --------------------------------------------------------------
  // wishbone decode
  // --------------------------------------------------------------
  wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_byte  = req & wb_we_i & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire hit_flags = (wb_adr_i == `ADDR_FLAGS);
  wire hit_low   = (wb_adr_i == `ADDR_HOLD_LOW);
  wire hit_high  = (wb_adr_i == `ADDR_HOLD_HIGH);
  wire hit_ctrl  = (wb_adr_i == `ADDR_CONTROL);
  wire hit_en    = (wb_adr_i == `ADDR_ENABLES);
  wire wr_flags  = wr_byte & hit_flags;
  wire wr_low    = wr_byte & hit_low;
  wire wr_high   = wr_byte & hit_high & ~is_pwm;
  wire wr_ctrl   = wr_byte & hit_ctrl;
  wire wr_en     = wr_byte & hit_en;

  // --------------------------------------------------------------
  // capture path
  // --------------------------------------------------------------
  logic pin_rise;
  logic pin_fall;

  // pin level itself is watched, driven or not
  pin_edge_detect u_edge
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_in  (pin_a_in),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  wire div4_last  = (presc_q == `PRESC_LAST4);
  wire div16_last = (presc_q == `PRESC_LAST16);

  // qualified capture event per mode
  logic cap_event;
  always_comb
  begin
    cap_event = 1'b0;
    if (is_capture)
    begin
      unique case (mode_select[1:0])
        2'b00: cap_event = pin_fall;
        2'b01: cap_event = pin_rise;
        2'b10: cap_event = pin_rise & div4_last;
        2'b11: cap_event = pin_rise & div16_last;
      endcase
    end
  end

  // prescaler counts rises, wraps at its last count
  wire presc_used = is_capture & mode_select[1];
  logic [3:0] presc_d;
  always_comb
  begin
    presc_d = presc_q;
    if (!is_capture)
      presc_d = 4'h0;
    else if (presc_used && pin_rise)
      presc_d = cap_event ? 4'h0 : presc_q + 4'h1;
  end

  // --------------------------------------------------------------
  // compare path
  // --------------------------------------------------------------
  wire match      = (timer_value == hold_q);
  wire match_edge = match & ~match_prev_q;
  wire cmp_event  = is_compare & match_edge;
  wire special    = cmp_event & (mode_select == `MODE_SPECIAL);

  // compare output latch
  logic cmp_latch_d;
  always_comb
  begin
    cmp_latch_d = cmp_latch_q;
    if (mode_select == `MODE_OFF)
      cmp_latch_d = 1'b0;
    else if (cmp_event)
    begin
      unique case (mode_select)
        `MODE_TOGGLE: cmp_latch_d = ~cmp_latch_q;
        `MODE_SET:    cmp_latch_d = 1'b1;
        `MODE_CLEAR:  cmp_latch_d = 1'b0;
        default:      cmp_latch_d = cmp_latch_q;
      endcase
    end
  end

  // timer clear waits for next tick and needs a live match
  wire still_match = match & (mode_select == `MODE_SPECIAL);
  wire clear_now   = reset_pend_q & timer_tick & still_match;
  logic pend_d;
  always_comb
  begin
    pend_d = reset_pend_q;
    if (special)
      pend_d = 1'b1;
    else if (timer_tick || !still_match)
      pend_d = 1'b0;
  end

  // --------------------------------------------------------------
  // holding register and flags
  // --------------------------------------------------------------
  logic [15:0] hold_d;
  always_comb
  begin
    hold_d = hold_q;
    if (wr_low)
      hold_d[7:0] = wd;
    if (wr_high)
      hold_d[15:8] = wd;
    if (cap_event)
      hold_d = timer_value;
  end

  // set wins over a clearing write
  wire unit_set  = cap_event | cmp_event;
  wire unit_keep = wr_flags ? wd[`FLAG_UNIT_BIT] : unit_flag_q;
  wire tmr_keep  = wr_flags ? wd[`FLAG_TIMER_BIT] : timer_flag_q;
  wire unit_flag_d  = unit_set | unit_keep;
  wire timer_flag_d = timer_overflow | tmr_keep;

  // --------------------------------------------------------------
  // pin steering
  // --------------------------------------------------------------
  wire pol_ac = mode_select[1];
  wire pol_bd = mode_select[0];
  wire mod_ac = pwm_modulated ^ pol_ac;
  wire mod_bd = pwm_modulated ^ pol_bd;
  wire nmod_bd = ~pwm_modulated ^ pol_bd;

  logic [3:0] pin_val_d;
  logic [3:0] pin_oe_n_d;
  always_comb
  begin
    pin_val_d  = 4'h0;
    pin_oe_n_d = 4'hF;
    if (is_compare)
    begin
      pin_val_d[0]  = cmp_latch_q;
      pin_oe_n_d[0] = 1'b0;
    end
    else if (is_pwm)
    begin
      unique case (output_configuration)
        2'b00:
        begin
          pin_val_d  = {3'b000, mod_ac};
          pin_oe_n_d = 4'hE;
        end
        2'b01:
        begin
          pin_val_d  = {mod_bd, pol_ac, pol_bd, ~pol_ac};
          pin_oe_n_d = 4'h0;
        end
        2'b10:
        begin
          pin_val_d  = {2'b00, nmod_bd, mod_ac};
          pin_oe_n_d = 4'hC;
        end
        2'b11:
        begin
          pin_val_d  = {pol_bd, ~pol_ac, mod_bd, pol_ac};
          pin_oe_n_d = 4'h0;
        end
      endcase
    end
  end

  // duty value exists only in PWM
  wire [9:0] duty_d = is_pwm ? {hold_q[7:0], duty_low_bits} : 10'h000;

  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_flags)
    begin
      rd_byte[`FLAG_UNIT_BIT]  = unit_flag_q;
      rd_byte[`FLAG_TIMER_BIT] = timer_flag_q;
    end
    else if (hit_low)
      rd_byte = hold_q[7:0];
    else if (hit_high)
      rd_byte = hold_q[15:8];
    else if (hit_ctrl)
      rd_byte = control_q;
    else if (hit_en)
      rd_byte = enables_q;
  end

  // --------------------------------------------------------------
  // bus and control registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      control_q <= `CONTROL_RESET;
      enables_q <= `ENABLES_RESET;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {24'h000000, rd_byte} : 32'h00000000;
      if (wr_ctrl)
        control_q <= wd;
      if (wr_en)
        enables_q <= wd;
    end
  end

  // --------------------------------------------------------------
  // capture/compare state
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      hold_q       <= `HOLD_RESET;
      unit_flag_q  <= 1'b0;
      timer_flag_q <= 1'b0;
      presc_q      <= 4'h0;
      cmp_latch_q  <= 1'b0;
      match_prev_q <= 1'b0;
      reset_pend_q <= 1'b0;
    end
    else
    begin
      hold_q       <= hold_d;
      unit_flag_q  <= unit_flag_d;
      timer_flag_q <= timer_flag_d;
      presc_q      <= presc_d;
      cmp_latch_q  <= cmp_latch_d;
      match_prev_q <= match;
      reset_pend_q <= pend_d;
    end
  end

  // --------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      output_a        <= 1'b0;
      output_b        <= 1'b0;
      output_c        <= 1'b0;
      output_d        <= 1'b0;
      output_a_oe_n   <= 1'b1;
      output_b_oe_n   <= 1'b1;
      output_c_oe_n   <= 1'b1;
      output_d_oe_n   <= 1'b1;
      special_trigger <= 1'b0;
      timer_clear     <= 1'b0;
      adc_start       <= 1'b0;
      duty_value      <= 10'h000;
    end
    else
    begin
      output_a        <= pin_val_d[0];
      output_b        <= pin_val_d[1];
      output_c        <= pin_val_d[2];
      output_d        <= pin_val_d[3];
      output_a_oe_n   <= pin_oe_n_d[0];
      output_b_oe_n   <= pin_oe_n_d[1];
      output_c_oe_n   <= pin_oe_n_d[2];
      output_d_oe_n   <= pin_oe_n_d[3];
      special_trigger <= special;
      timer_clear     <= clear_now;
      adc_start       <= special & adc_enabled;
      duty_value      <= duty_d;
    end
  end

endmodule

// ---- core/capture_compare_defines.svh ----
`ifndef CAPTURE_COMPARE_DEFINES_SVH
`define CAPTURE_COMPARE_DEFINES_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_FLAGS       12'h00C
`define IDX_HOLD_LOW    12'h015
`define IDX_HOLD_HIGH   12'h016
`define IDX_CONTROL     12'h017
`define IDX_ENABLES     12'h08C
`define ADDR_FLAGS      12'h030
`define ADDR_HOLD_LOW   12'h054
`define ADDR_HOLD_HIGH  12'h058
`define ADDR_CONTROL    12'h05C
`define ADDR_ENABLES    12'h230

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FLAG_UNIT_BIT   2
`define FLAG_TIMER_BIT  0
`define CONTROL_RESET   8'h00
`define ENABLES_RESET   8'h00
`define HOLD_RESET      16'h0000
`define MODE_OFF        4'h0
`define MODE_TOGGLE     4'h2
`define MODE_CAP_FALL   4'h4
`define MODE_CAP_RISE   4'h5
`define MODE_CAP_DIV4   4'h6
`define MODE_CAP_DIV16  4'h7
`define MODE_SET        4'h8
`define MODE_CLEAR      4'h9
`define MODE_SOFT       4'hA
`define MODE_SPECIAL    4'hB
`define PRESC_LAST4     4'h3
`define PRESC_LAST16    4'hF

`endif

// ---- core/capture_compare_pkg.sv ----
package capture_compare_pkg;

  // broad class of the mode select field
  typedef enum logic [2:0] {
    class_off,
    class_reserved,
    class_capture,
    class_compare,
    class_pwm
  } mode_class_type;

endpackage

// ---- core/pin_edge_detect.sv ----
`timescale 1ns/1ps
`include "capture_compare_defines.svh"

module pin_edge_detect
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // --------------------------------------------------------------
  // two-stage synchroniser, then edge compare on the clean copy
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges from synchronised samples only
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

// ---- verification/capture_compare_monitor.sv ----
`timescale 1ns/1ps
// ----
// bus, event and pin checks
// ----
module capture_compare_monitor
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        timer_tick,
  input wire logic        special_trigger,
  input wire logic        timer_clear,
  input wire logic        adc_start,
  input wire logic        output_a,
  input wire logic        output_b,
  input wire logic        output_c,
  input wire logic        output_d,
  input wire logic        output_a_oe_n,
  input wire logic        output_b_oe_n,
  input wire logic        output_c_oe_n,
  input wire logic        output_d_oe_n
);
  // single clock domain, synchronous reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_data_clean: assert property (wb_dat_o[31:8] == 24'h000000 && (wb_ack_o || wb_dat_o[7:0] == 8'h00))
    else $error("read data outside its cycle");
  a_adc_with_trigger: assert property (adc_start |-> special_trigger)
    else $error("conversion start without trigger");
  a_trigger_onset: assert property (special_trigger |=> !special_trigger)
    else $error("trigger longer than match onset");
  a_clear_after_tick: assert property (timer_clear |-> $past(timer_tick))
    else $error("timer clear off the timer tick");
  a_pins_released: assert property (!(output_a_oe_n && output_a) && !(output_b_oe_n && output_b)
    && !(output_c_oe_n && output_c) && !(output_d_oe_n && output_d))
    else $error("released pin not low");
  a_reset_idle: assert property ($rose(reset_n) |-> output_a_oe_n && output_b_oe_n
    && output_c_oe_n && output_d_oe_n && !timer_clear && !adc_start)
    else $error("outputs not idle after reset");
endmodule

// ---- verification/timer_model.sv ----
`timescale 1ns/1ps
// ----
// synchronous sixteen-bit timer on the far side
// ----
module timer_model #(parameter int TICK_DIV = 16)
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire logic        load_en,
  input  wire logic [15:0] load_value,
  input  wire logic        timer_clear,
  output logic      [15:0] timer_value,
  output logic             timer_tick,
  output logic             timer_overflow
);
  logic [7:0] div_q;

  // timer clock prescale, tick marks each timer clock rising edge
  always_ff @(posedge clk_sys)
    if (!reset_n || div_q == 8'(TICK_DIV - 1))
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  assign timer_tick     = run && div_q == 8'(TICK_DIV - 1);
  assign timer_overflow = timer_tick && timer_value == 16'hFFFF;

  // count, preload from the bench, clear from the unit
  always_ff @(posedge clk_sys)
    if (!reset_n)
      timer_value <= 16'h0000;
    else if (load_en)
      timer_value <= load_value;
    else if (timer_clear)
      timer_value <= 16'h0000;
    else if (timer_tick)
      timer_value <= timer_value + 16'h0001;
endmodule

// ---- verification/tb_enhanced_capture_compare_unit.sv ----
`timescale 1ns/1ps
`include "capture_compare_defines.svh"
module tb_enhanced_capture_compare_unit;
  logic        clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, timer_tick;
  logic        timer_overflow, adc_enabled, pwm_modulated, pin_a_in, run, load_en;
  logic        output_a, output_b, output_c, output_d, special_trigger, timer_clear;
  logic        output_a_oe_n, output_b_oe_n, output_c_oe_n, output_d_oe_n, adc_start;
  logic [3:0]  wb_sel_i, md;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] timer_value, load_value, v;
  logic [9:0]  duty_value;
  logic [7:0]  lb, exp_q[$];
  logic [1:0]  cf, dl;
  int          n_mismatch = 0, checks = 0, n_trig = 0, n_adc = 0, n_clr = 0;
  int          cnt[4] = '{1, 1, 4, 16};
  logic [3:0]  cmp_md[4] = '{`MODE_SET, `MODE_CLEAR, `MODE_TOGGLE, `MODE_SOFT};
  logic        cmp_pin[4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  enhanced_capture_compare_unit u_enhanced_capture_compare_unit (.clk_sys, .reset_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .timer_value, .timer_tick, .timer_overflow, .adc_enabled, .pwm_modulated, .pin_a_in,
    .output_a, .output_b, .output_c, .output_d, .output_a_oe_n, .output_b_oe_n,
    .output_c_oe_n, .output_d_oe_n, .special_trigger, .timer_clear, .adc_start, .duty_value);
  timer_model u_timer_model (.clk_sys, .reset_n, .run, .load_en, .load_value, .timer_clear,
    .timer_value, .timer_tick, .timer_overflow);

  // ----
  // shared tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, w, 4'h1};
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    @(posedge clk_sys);
    // request held until ack is seen; a hang is left to the watchdog
    while (wb_ack_o !== 1'b1)
      @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic set_timer(input logic [15:0] t);
    load_value <= t;
    load_en <= 1'b1;
    idle(1);
    load_en <= 1'b0;
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      pin_a_in <= 1'b1;
      idle(5);
      pin_a_in <= 1'b0;
      idle(6);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // expected {oe_n d..a, pins d..a} for one pwm setting
  function automatic logic [7:0] pwm_exp(input logic [3:0] m4, input logic [1:0] c, input logic m);
    case (c)
      2'h0: pwm_exp = {4'hE, 3'h0, m ^ m4[1]};
      2'h1: pwm_exp = {4'h0, m ^ m4[0], m4[1], m4[0], ~m4[1]};
      2'h2: pwm_exp = {4'hC, 2'h0, ~m ^ m4[0], m ^ m4[1]};
      default: pwm_exp = {4'h0, m4[0], ~m4[1], m ^ m4[0], m4[1]};
    endcase
  endfunction

  // clock, read watcher, event counters, watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      check(wb_dat_o[7:0], exp_q.pop_front(), "read data");
  always @(posedge clk_sys)
  begin
    if (special_trigger === 1'b1) n_trig++;
    if (adc_start === 1'b1) n_adc++;
    if (timer_clear === 1'b1) n_clr++;
  end
  initial
  begin
    idle(20000);
    n_mismatch++;
    end_sim;
  end

  // ----
  // main sequence
  // ----
  initial
  begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, adc_enabled, pwm_modulated, pin_a_in} = 7'h00;
    {run, load_en, wb_sel_i, wb_adr_i, wb_dat_i, load_value} = 0;
    void'($urandom(32'hD05656A4));
    idle(4);
    reset_n <= 1'b1;
    idle(1);
    rd(`ADDR_FLAGS, 8'h00);
    rd(`ADDR_CONTROL, 8'h00);
    rd(`ADDR_ENABLES, 8'h00);
    rd(`ADDR_HOLD_LOW, 8'h00);
    wr(12'h100, 8'hFF);
    rd(12'h100, 8'h00);
    wr(`ADDR_ENABLES, 8'h01);
    rd(`ADDR_ENABLES, 8'h01);
    wr(`ADDR_HOLD_LOW, 8'hA5);
    wr(`ADDR_HOLD_HIGH, 8'h3C);
    rd(`ADDR_HOLD_LOW, 8'hA5);
    rd(`ADDR_HOLD_HIGH, 8'h3C);
    // capture on each edge kind with a stopped timer
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($urandom);
      set_timer(v);
      wr(`ADDR_CONTROL, 8'h00);
      wr(`ADDR_CONTROL, 8'(4 + i));
      wr(`ADDR_FLAGS, 8'h00);
      pulses(cnt[i] - 1);
      rd(`ADDR_FLAGS, 8'h00);
      pulses(1);
      rd(`ADDR_FLAGS, 8'h04);
      rd(`ADDR_HOLD_LOW, v[7:0]);
      rd(`ADDR_HOLD_HIGH, v[15:8]);
      check(output_a_oe_n, 1'b1, "capture pin released");
    end
    set_timer(16'h5678);
    pulses(16);
    set_timer(16'h1234);
    pulses(16);
    rd(`ADDR_HOLD_LOW, 8'h34);
    rd(`ADDR_HOLD_HIGH, 8'h12);
    // prescale switch keeps the count
    wr(`ADDR_CONTROL, 8'h00);
    wr(`ADDR_CONTROL, {4'h0, `MODE_CAP_DIV4});
    pulses(2);
    wr(`ADDR_CONTROL, {4'h0, `MODE_CAP_DIV16});
    wr(`ADDR_FLAGS, 8'h00);
    pulses(13);
    rd(`ADDR_FLAGS, 8'h00);
    pulses(1);
    rd(`ADDR_FLAGS, 8'h04);
    // compare actions with a running timer
    run <= 1'b1;
    wr(`ADDR_CONTROL, 8'h00);
    wr(`ADDR_HOLD_LOW, 8'h40);
    wr(`ADDR_HOLD_HIGH, 8'h12);
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADDR_CONTROL, {4'hF, cmp_md[i]});
      wr(`ADDR_FLAGS, 8'h00);
      set_timer(16'h123D);
      idle(80);
      check(output_a, cmp_pin[i], "compare pin");
      check({output_d_oe_n, output_c_oe_n, output_b_oe_n, output_a_oe_n}, 4'hE, "drive");
      check(duty_value, 10'h000, "duty outside pwm");
      rd(`ADDR_FLAGS, 8'h04);
    end
    wr(`ADDR_CONTROL, 8'h03);
    idle(2);
    check(output_a_oe_n, 1'b1, "reserved released");
    wr(`ADDR_CONTROL, 8'h0A);
    idle(2);
    check(output_a, 1'b1, "latch held");
    wr(`ADDR_CONTROL, 8'h00);
    wr(`ADDR_CONTROL, 8'h0A);
    idle(2);
    check(output_a, 1'b0, "latch cleared");
    // special event, overflow flag, then a cancelled clear
    adc_enabled <= 1'b1;
    wr(`ADDR_CONTROL, {4'h0, `MODE_SPECIAL});
    wr(`ADDR_FLAGS, 8'h00);
    set_timer(16'h123D);
    idle(80);
    check(16'(n_trig), 16'h0001, "trigger count");
    check(16'(n_adc), 16'h0001, "conversion starts");
    check(16'(n_clr), 16'h0001, "timer clears");
    check(timer_value < 16'h0010, 1'b1, "timer restarted");
    rd(`ADDR_FLAGS, 8'h04);
    set_timer(16'hFFFE);
    idle(40);
    rd(`ADDR_FLAGS, 8'h05);
    adc_enabled <= 1'b0;
    set_timer(16'h123F);
    for (int n = 0; n < 40 && special_trigger !== 1'b1; n++)
      idle(1);
    wr(`ADDR_HOLD_LOW, 8'h00);
    idle(40);
    check(16'(n_trig), 16'h0002, "trigger count");
    check(16'(n_adc), 16'h0001, "conversion disabled");
    check(16'(n_clr), 16'h0001, "clear cancelled");
    // pwm steering, polarity and duty for every mode and configuration
    for (int i = 0; i < 16; i++)
    begin
      cf = 2'(i);
      md = {2'h3, 2'(i >> 2)};
      dl = 2'($urandom);
      lb = 8'($urandom);
      wr(`ADDR_HOLD_LOW, lb);
      wr(`ADDR_CONTROL, {cf, dl, md});
      for (int j = 0; j < 2; j++)
      begin
        pwm_modulated <= j[0];
        idle(4);
        check({output_d_oe_n, output_c_oe_n, output_b_oe_n, output_a_oe_n, output_d, output_c,
          output_b, output_a}, pwm_exp(md, cf, j[0]), "pwm pins");
      end
      check(duty_value, {lb, dl}, "duty value");
    end
    // high half is read-only while in pwm
    wr(`ADDR_HOLD_HIGH, 8'hC3);
    rd(`ADDR_HOLD_HIGH, 8'h12);
    end_sim;
  end
endmodule

bind enhanced_capture_compare_unit capture_compare_monitor u_capture_compare_monitor (.clk_sys,
  .reset_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .timer_tick, .special_trigger,
  .timer_clear, .adc_start, .output_a, .output_b, .output_c, .output_d, .output_a_oe_n,
  .output_b_oe_n, .output_c_oe_n, .output_d_oe_n);
